// file: bench/sce_engine_bench.sv
`timescale 1ns/1ns
`default_nettype none
module sce_engine_bench;
  import sce_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, fail, synack, tto;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [10:0] ev, acts, act_seen;
  logic [SIZE_W-1:0] ack_size, send_len;
  logic [7:0] ppp_cmd, ppp_code;
  logic [3:0] pr [5] = '{proto_tcp, proto_udp, proto_ip_raw, proto_pppoe, proto_mac_raw};
  sce_state_type os [5] = '{state_tcp_init, state_udp, state_ip_raw, state_pppoe,
    state_mac_raw};
  int fails, samples_checked, n, ka_n;
  sce_engine sce_engine_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt_syn_ok(ev[0]), .evt_synack_fail(ev[5]), .evt_synack_rx(synack),
    .arp_timeout(ev[6]), .tcp_timeout(tto), .evt_rst_rx(ev[1]), .evt_fin_rx(ev[8]),
    .evt_fin_ack_rx(ev[2]), .evt_data_rx(ev[9]), .evt_data_ack(ev[3]), .evt_ack_size(ack_size),
    .evt_send_done(ev[4]), .evt_ka_ack(ev[10]), .evt_no_port(ev[7]), .evt_ppp(3'h0),
    .act_open(acts[0]), .act_listen(acts[1]), .act_syn(acts[2]), .act_fin(acts[3]),
    .act_send(acts[4]), .act_send_split(acts[5]), .act_use_dest_mac(acts[6]),
    .act_send_len(send_len), .keepalive_packet(acts[7]), .act_recv_done(acts[8]),
    .act_ppp(acts[9]), .act_ppp_cmd(ppp_cmd), .act_rst_reply(acts[10]));
  sce_peer sce_peer_inst (.pclk(pclk), .presetn(presetn), .act_syn(acts[2]), .fail(fail),
    .evt_synack_rx(synack), .tcp_timeout(tto));
  // sticky record of every action strobe, last pppoe code, keepalive count
  always @(posedge pclk) begin
    act_seen <= presetn ? act_seen | acts : '0;
    if (acts[9]) ppp_code <= ppp_cmd;
    if (acts[7]) ka_n <= ka_n + 1;
  end
  // 8 ns clock
  initial forever #4 pclk = ~pclk;
  // four-state compare so an unknown matches only an unknown
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // counts, verdict, stop
  task end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input logic w, input logic [IDX_W-1:0] idx, input logic [31:0] d);
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) fails++;
    if (n >= 20) end_of_test();
  endtask
  // read a register and compare
  task rdc(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  // command write; it must read back cleared
  task cmd(input logic [7:0] c);
    apb(1'b1, IDX_COMMAND, 32'(c));
    repeat (3) @(posedge pclk);
    rdc(IDX_COMMAND, 32'h0);
  endtask
  // one-cycle packet event
  task pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
  endtask
  // reset, then the scenarios in turn
  initial begin
    {pclk, presetn, psel, penable, pwrite, fail, ev, ack_size, paddr, pwdata} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(IDX_STATE, 32'(state_closed));
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, IDX_MODE, 32'(pr[i]));
      cmd(cmd_open);
      cmd(cmd_session_start);
      cmd(cmd_send_direct_mac);
      rdc(IDX_STATE, 32'(os[i]));
      cmd(cmd_close);
      rdc(IDX_STATE, 32'(state_closed));
    end
    // raw ethernet refused away from socket zero
    apb(1'b1, IDX_SOCK_ID, 32'h1);
    cmd(cmd_open);
    rdc(IDX_STATE, 32'(state_closed));
    // server: listen, then a handled syn
    apb(1'b1, IDX_MODE, 32'(proto_tcp));
    cmd(cmd_open);
    cmd(cmd_listen);
    rdc(IDX_STATE, 32'(state_listening));
    pulse(0);
    rdc(IDX_STATE, 32'(state_connected));
    rdc(IDX_FLAGS, 32'h0000_0001);
    // peer reset drops the link; a failed syn/ack reply times out
    pulse(1);
    rdc(IDX_STATE, 32'(state_closed));
    cmd(cmd_open);
    cmd(cmd_listen);
    pulse(5);
    rdc(IDX_STATE, 32'(state_closed));
    rdc(IDX_FLAGS, 32'h0000_0009);
    // client: peer times out first, then answers
    for (int i = 1; i >= 0; i--) begin
      apb(1'b1, IDX_FLAGS, 32'h0000_00FF);
      fail <= i[0];
      cmd(cmd_open);
      cmd(cmd_connect);
      repeat (20) @(posedge pclk);
      rdc(IDX_STATE, 32'(i ? state_closed : state_connected));
      rdc(IDX_FLAGS, i ? 32'h0000_0008 : 32'h0000_0001);
    end
    // send: length first, space drops, ack returns it
    apb(1'b1, IDX_WRITE_SIZE, 32'h0000_0010);
    cmd(cmd_send);
    rdc(IDX_FREE_SIZE, 32'h0000_1FF0);
    ack_size <= 17'h0_0010;
    pulse(3);
    rdc(IDX_FREE_SIZE, 32'(FREE_RESET));
    // host waits for send-complete before any further send
    pulse(4);
    rdc(IDX_FLAGS, 32'h0000_0011);
    // keepalive refused while the timer runs, taken once it is zero
    apb(1'b1, IDX_KA_TIMER, 32'h0000_0005);
    cmd(cmd_keepalive);
    apb(1'b1, IDX_KA_TIMER, 32'h0);
    cmd(cmd_keepalive);
    chk(ka_n, 32'h1);
    pulse(10);
    pulse(9);
    cmd(cmd_recv_done);
    pulse(7);
    rdc(IDX_STATE, 32'(state_connected));
    // passive close: peer fin first, then our disconnect
    pulse(8);
    rdc(IDX_STATE, 32'(state_close_wait));
    cmd(cmd_disconnect);
    pulse(2);
    rdc(IDX_STATE, 32'(state_closed));
    rdc(IDX_FLAGS, 32'h0000_0017);
    chk(act_seen, 32'h0000_07FF);
    chk(32'(send_len), 32'h0000_0010);
    chk(32'(ppp_code), 32'(cmd_session_start));
    // unmapped place answers with an error
    rdc(10'h3FF, 32'h0);
    chk({31'h0, err}, 32'h1);
    end_of_test();
  end
endmodule // sce_engine_bench
`default_nettype wire

// file: bench/sce_peer.sv
`timescale 1ns/1ns
`default_nettype none
// far end: answers each syn after a delay, or lets it time out
module sce_peer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic act_syn,
  input wire logic fail,
  output logic evt_synack_rx,
  output logic tcp_timeout
);
  logic [3:0] dly_ff;
  // slow reply so the syn-sent status is visible first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_ff <= 4'h0;
      evt_synack_rx <= 1'b0;
      tcp_timeout <= 1'b0;
    end else begin
      dly_ff <= act_syn ? 4'hC : dly_ff - {3'h0, dly_ff != 4'h0};
      evt_synack_rx <= dly_ff == 4'h1 && !fail;
      tcp_timeout <= dly_ff == 4'h1 && fail;
    end
  end
endmodule // sce_peer
`default_nettype wire

// file: common/sce_dec_if.sv
`timescale 1ns/1ns
`default_nettype none
// command decode request and verdict between engine and decoder
interface sce_dec_if;
  import sce_pkg::*;
  logic [7:0] cmd;
  logic [3:0] proto;
  sce_state_type state;
  logic ka_zero;
  logic data_seen;
  logic send_busy;
  logic cmd_ok;
  sce_state_type nxt_state;
  modport eng (output cmd, proto, state, ka_zero, data_seen, send_busy,
    input cmd_ok, nxt_state);
  modport dec (input cmd, proto, state, ka_zero, data_seen, send_busy,
    output cmd_ok, nxt_state);
endinterface
`default_nettype wire

// file: common/sce_pkg.sv
`default_nettype none
package sce_pkg;
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam int SIZE_W = 17;
  localparam int KA_W = 8;
  localparam int SOCK_W = 3;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MODE = 10'h200;
  localparam logic [IDX_W-1:0] IDX_COMMAND = 10'h202;
  localparam logic [IDX_W-1:0] IDX_FLAGS = 10'h206;
  localparam logic [IDX_W-1:0] IDX_STATE = 10'h208;
  localparam logic [IDX_W-1:0] IDX_KA_TIMER = 10'h21C;
  localparam logic [IDX_W-1:0] IDX_WRITE_SIZE = 10'h220;
  localparam logic [IDX_W-1:0] IDX_FREE_SIZE = 10'h224;
  localparam logic [IDX_W-1:0] IDX_SOCK_ID = 10'h23E;

  // reset values
  localparam logic [15:0] MODE_RESET = 16'h0020;
  localparam logic [SIZE_W-1:0] FREE_RESET = 17'h0_2000;

  // mode register field
  localparam int PROTO_LSB = 0;
  localparam int PROTO_W = 4;
  localparam logic [3:0] proto_closed = 4'h0;
  localparam logic [3:0] proto_tcp = 4'h1;
  localparam logic [3:0] proto_udp = 4'h2;
  localparam logic [3:0] proto_ip_raw = 4'h3;
  localparam logic [3:0] proto_mac_raw = 4'h4;
  localparam logic [3:0] proto_pppoe = 4'h5;

  // command codes
  localparam logic [7:0] cmd_none = 8'h00;
  localparam logic [7:0] cmd_open = 8'h01;
  localparam logic [7:0] cmd_listen = 8'h02;
  localparam logic [7:0] cmd_connect = 8'h04;
  localparam logic [7:0] cmd_disconnect = 8'h08;
  localparam logic [7:0] cmd_close = 8'h10;
  localparam logic [7:0] cmd_send = 8'h20;
  localparam logic [7:0] cmd_send_direct_mac = 8'h21;
  localparam logic [7:0] cmd_keepalive = 8'h22;
  localparam logic [7:0] cmd_session_start = 8'h23;
  localparam logic [7:0] cmd_session_end = 8'h24;
  localparam logic [7:0] cmd_phase_request = 8'h25;
  localparam logic [7:0] cmd_phase_nak = 8'h26;
  localparam logic [7:0] cmd_phase_reject = 8'h27;
  localparam logic [7:0] cmd_recv_done = 8'h40;

  // event flag bit positions
  localparam int FLG_N = 8;
  localparam int FLG_CONNECT = 0;
  localparam int FLG_DISCONNECT = 1;
  localparam int FLG_RECEIVE = 2;
  localparam int FLG_TIMEOUT = 3;
  localparam int send_complete_flag = 4;
  localparam int FLG_PPP_LSB = 5;
  localparam int PPP_W = 3;

  // socket status codes
  typedef enum logic [7:0] {
    state_closed = 8'h00,
    state_tcp_init = 8'h13,
    state_listening = 8'h14,
    state_syn_sent = 8'h15,
    state_connected = 8'h17,
    state_fin_wait = 8'h18,
    state_close_wait = 8'h1C,
    state_udp = 8'h22,
    state_ip_raw = 8'h32,
    state_mac_raw = 8'h42,
    state_pppoe = 8'h5F
  } sce_state_type;
endpackage
`default_nettype wire

// file: rtl/sce_cmd_decode.sv
`timescale 1ns/1ns
`default_nettype none
// judges a command against protocol and status, gives the target status
module sce_cmd_decode (
  sce_dec_if.dec dec
);
  import sce_pkg::*;
  logic is_tcp;
  logic tcp_open;
  logic dgram_open;
  logic raw_open;

  // mac raw and pppoe already masked to closed for non-zero sockets by the engine
  assign is_tcp = (dec.proto == proto_tcp);
  assign tcp_open = is_tcp && (dec.state == state_connected || dec.state == state_close_wait);
  assign dgram_open = (dec.proto == proto_udp && dec.state == state_udp) ||
    (dec.proto == proto_ip_raw && dec.state == state_ip_raw);
  assign raw_open = (dec.proto == proto_mac_raw && dec.state == state_mac_raw);

  // anything not matched is refused and leaves the status alone
  always_comb begin
    dec.cmd_ok = 1'b0;
    dec.nxt_state = dec.state;
    case (dec.cmd)
      cmd_open: begin
        if (dec.state == state_closed) begin
          dec.cmd_ok = (dec.proto != proto_closed);
          case (dec.proto)
            proto_tcp: dec.nxt_state = state_tcp_init;
            proto_udp: dec.nxt_state = state_udp;
            proto_ip_raw: dec.nxt_state = state_ip_raw;
            proto_mac_raw: dec.nxt_state = state_mac_raw;
            proto_pppoe: dec.nxt_state = state_pppoe;
            default: dec.cmd_ok = 1'b0;
          endcase
        end
      end
      cmd_listen: begin
        if (is_tcp && dec.state == state_tcp_init) begin
          dec.cmd_ok = 1'b1;
          dec.nxt_state = state_listening;
        end
      end
      cmd_connect: begin
        if (is_tcp && dec.state == state_tcp_init) begin
          dec.cmd_ok = 1'b1;
          dec.nxt_state = state_syn_sent;
        end
      end
      cmd_disconnect: begin
        if (tcp_open) begin
          dec.cmd_ok = 1'b1;
          dec.nxt_state = state_fin_wait;
        end
      end
      cmd_close: begin
        dec.cmd_ok = 1'b1;
        dec.nxt_state = state_closed;
      end
      cmd_send: begin
        dec.cmd_ok = !dec.send_busy && (tcp_open || dgram_open || raw_open);
      end
      cmd_send_direct_mac: begin
        dec.cmd_ok = !dec.send_busy && dgram_open;
      end
      cmd_keepalive: begin
        dec.cmd_ok = is_tcp && dec.state == state_connected && dec.ka_zero && dec.data_seen;
      end
      cmd_recv_done: begin
        dec.cmd_ok = (dec.state != state_closed);
      end
      cmd_session_start, cmd_session_end, cmd_phase_request, cmd_phase_nak,
      cmd_phase_reject: begin
        dec.cmd_ok = (dec.proto == proto_pppoe);
      end
      default: begin
        dec.cmd_ok = 1'b0;
      end
    endcase
  end
endmodule // sce_cmd_decode
`default_nettype wire

// file: rtl/sce_engine.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module sce_engine (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sce_pkg::ADDR_W-1:0] paddr,
  input wire logic [sce_pkg::DATA_W-1:0] pwdata,
  output logic [sce_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic evt_syn_ok,
  input wire logic evt_synack_fail,
  input wire logic evt_synack_rx,
  input wire logic arp_timeout,
  input wire logic tcp_timeout,
  input wire logic evt_rst_rx,
  input wire logic evt_fin_rx,
  input wire logic evt_fin_ack_rx,
  input wire logic evt_data_rx,
  input wire logic evt_data_ack,
  input wire logic [sce_pkg::SIZE_W-1:0] evt_ack_size,
  input wire logic evt_send_done,
  input wire logic evt_ka_ack,
  input wire logic evt_no_port,
  input wire logic [sce_pkg::PPP_W-1:0] evt_ppp,
  output logic act_open,
  output logic act_listen,
  output logic act_syn,
  output logic act_fin,
  output logic act_send,
  output logic act_send_split,
  output logic act_use_dest_mac,
  output logic [sce_pkg::SIZE_W-1:0] act_send_len,
  output logic keepalive_packet,
  output logic act_recv_done,
  output logic act_ppp,
  output logic [7:0] act_ppp_cmd,
  output logic act_rst_reply
);
  import sce_pkg::*;

  sce_dec_if dif ();
  logic [15:0] mode_ff;
  logic [7:0] cmd_ff;
  logic [KA_W-1:0] ka_timer_ff;
  logic [SIZE_W-1:0] wsize_ff;
  logic [SIZE_W-1:0] free_ff;
  logic [SOCK_W-1:0] sock_id_ff;
  sce_state_type state_ff;
  sce_state_type nxt_state;
  logic send_busy_ff;
  logic data_seen_ff;
  logic [FLG_N-1:0] flags;
  logic [FLG_N-1:0] flag_set;
  logic [FLG_N-1:0] flag_clr;
  logic rdy_ff;
  logic err_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] rdata;
  logic hit;
  logic wr;
  logic [IDX_W-1:0] idx;
  logic [3:0] proto_field;
  logic [3:0] proto_eff;
  logic exec;
  logic go;
  logic tcp_live;
  logic in_tcp;
  logic act_send_pre;

  assign idx = paddr[ADDR_W-1:2];
  assign proto_field = mode_ff[PROTO_LSB +: PROTO_W];
  // mac raw and pppoe on another socket fall back to closed
  assign proto_eff = ((proto_field == proto_mac_raw || proto_field == proto_pppoe) &&
    sock_id_ff != '0) ? proto_closed : proto_field;
  assign exec = (cmd_ff != cmd_none);
  assign go = exec && dif.cmd_ok;
  assign wr = psel && penable && rdy_ff && pwrite && !err_ff;
  assign in_tcp = (proto_eff == proto_tcp);
  assign act_send_pre = go && (cmd_ff == cmd_send || cmd_ff == cmd_send_direct_mac);
  // states in which a peer reset or retransmit timeout ends the link
  assign tcp_live = (state_ff == state_listening || state_ff == state_syn_sent ||
    state_ff == state_connected || state_ff == state_close_wait || state_ff == state_fin_wait);

  // decoder request
  assign dif.cmd = cmd_ff;
  assign dif.proto = proto_eff;
  assign dif.state = state_ff;
  assign dif.ka_zero = (ka_timer_ff == '0);
  assign dif.data_seen = data_seen_ff;
  assign dif.send_busy = send_busy_ff;

  sce_cmd_decode u_dec (
    .dec(dif)
  );

  // read mux; unmapped or misaligned answers with an error
  always_comb begin
    rdata = '0;
    hit = (paddr[1:0] == 2'b00);
    case (idx)
      IDX_MODE: rdata[15:0] = mode_ff;
      IDX_COMMAND: rdata[7:0] = cmd_ff;
      IDX_FLAGS: rdata[FLG_N-1:0] = flags;
      IDX_STATE: rdata[7:0] = state_ff;
      IDX_KA_TIMER: rdata[KA_W-1:0] = ka_timer_ff;
      IDX_WRITE_SIZE: rdata[SIZE_W-1:0] = wsize_ff;
      IDX_FREE_SIZE: rdata[SIZE_W-1:0] = free_ff;
      IDX_SOCK_ID: rdata[SOCK_W-1:0] = sock_id_ff;
      default: hit = 1'b0;
    endcase
  end

  // one wait-free access phase: answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_ff <= 1'b0;
      err_ff <= 1'b0;
      rdata_ff <= '0;
    end else if (psel && !penable) begin
      rdy_ff <= 1'b1;
      err_ff <= !hit;
      rdata_ff <= rdata;
    end else begin
      rdy_ff <= 1'b0;
      err_ff <= 1'b0;
    end
  end

  assign prdata = rdata_ff;
  assign pready = rdy_ff;
  assign pslverr = err_ff;

  // plain software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= MODE_RESET;
      ka_timer_ff <= '0;
      wsize_ff <= '0;
      sock_id_ff <= '0;
    end else if (wr) begin
      if (idx == IDX_MODE) mode_ff <= pwdata[15:0];
      if (idx == IDX_KA_TIMER) ka_timer_ff <= pwdata[KA_W-1:0];
      if (idx == IDX_WRITE_SIZE) wsize_ff <= pwdata[SIZE_W-1:0];
      if (idx == IDX_SOCK_ID) sock_id_ff <= pwdata[SOCK_W-1:0];
    end
  end

  // a fresh write beats the self-clear; any detected code is wiped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff <= cmd_none;
    end else if (wr && idx == IDX_COMMAND) begin
      cmd_ff <= pwdata[7:0];
    end else if (exec) begin
      cmd_ff <= cmd_none;
    end
  end

  // status: packet events take priority over any command except close in the same cycle
  always_comb begin
    nxt_state = state_ff;
    if (go) nxt_state = dif.nxt_state;
    case (state_ff)
      state_listening: begin
        if (evt_syn_ok) nxt_state = state_connected;
        else if (evt_synack_fail) nxt_state = state_closed;
      end
      state_syn_sent: begin
        if (evt_synack_rx) nxt_state = state_connected;
        else if (arp_timeout) nxt_state = state_closed;
      end
      state_connected: begin
        if (evt_fin_rx) nxt_state = state_close_wait;
      end
      state_fin_wait: begin
        if (evt_fin_ack_rx) nxt_state = state_closed;
      end
      default: nxt_state = nxt_state;
    endcase
    // close wins over any packet event, it needs no peer answer
    if (go && cmd_ff == cmd_close) nxt_state = state_closed;
    // timeouts of syn, data, keepalive and fin all land here
    if (tcp_live && (tcp_timeout || evt_rst_rx)) begin
      nxt_state = state_closed;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= state_closed;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // one send at a time; busy ends with completion or teardown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_busy_ff <= 1'b0;
    end else if (nxt_state == state_closed) begin
      send_busy_ff <= 1'b0;
    end else if (go && (cmd_ff == cmd_send || cmd_ff == cmd_send_direct_mac)) begin
      send_busy_ff <= 1'b1;
    end else if (evt_send_done) begin
      send_busy_ff <= 1'b0;
    end
  end

  // keepalive needs one exchange on this connection first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_seen_ff <= 1'b0;
    end else if (state_ff == state_closed) begin
      data_seen_ff <= 1'b0;
    end else if (state_ff == state_connected && (evt_data_rx || evt_data_ack)) begin
      data_seen_ff <= 1'b1;
    end
  end

  // free space: acked bytes come back in tcp mode only, a send takes its size
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_ff <= FREE_RESET;
    end else begin
      free_ff <= free_ff +
        ((in_tcp && evt_data_ack) ? evt_ack_size : '0) -
        ((go && (cmd_ff == cmd_send || cmd_ff == cmd_send_direct_mac)) ? wsize_ff : '0);
    end
  end

  // event sources for the sticky flags
  always_comb begin
    flag_set = '0;
    flag_set[FLG_CONNECT] = (state_ff == state_listening && evt_syn_ok) ||
      (state_ff == state_syn_sent && evt_synack_rx);
    flag_set[FLG_DISCONNECT] = (state_ff == state_connected && evt_fin_rx);
    flag_set[FLG_RECEIVE] = (state_ff != state_closed) && evt_data_rx;
    flag_set[FLG_TIMEOUT] = (state_ff == state_listening && evt_synack_fail && !evt_syn_ok) ||
      (state_ff == state_syn_sent && arp_timeout) ||
      (tcp_live && tcp_timeout);
    flag_set[send_complete_flag] = send_busy_ff && evt_send_done;
    if (proto_eff == proto_pppoe) begin
      flag_set[FLG_PPP_LSB +: PPP_W] = evt_ppp;
    end
    flag_clr = (wr && idx == IDX_FLAGS) ? pwdata[FLG_N-1:0] : '0;
  end

  for (genvar i = 0; i < FLG_N; i++) begin : g_flag
    sce_sticky_bit u_bit (
      .pclk(pclk),
      .presetn(presetn),
      .set_in(flag_set[i]),
      .clr_in(flag_clr[i]),
      .flag_ff(flags[i])
    );
  end

  // action strobes toward the packet engine, one cycle each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_open <= 1'b0;
      act_listen <= 1'b0;
      act_syn <= 1'b0;
      act_fin <= 1'b0;
      act_send <= 1'b0;
      act_send_split <= 1'b0;
      act_use_dest_mac <= 1'b0;
      act_send_len <= '0;
      keepalive_packet <= 1'b0;
      act_recv_done <= 1'b0;
      act_ppp <= 1'b0;
      act_ppp_cmd <= cmd_none;
    end else begin
      act_open <= go && cmd_ff == cmd_open;
      act_listen <= go && cmd_ff == cmd_listen;
      act_syn <= go && cmd_ff == cmd_connect;
      act_fin <= go && cmd_ff == cmd_disconnect;
      act_send <= go && (cmd_ff == cmd_send || cmd_ff == cmd_send_direct_mac);
      // only tcp and udp get mss splitting
      act_send_split <= go && cmd_ff == cmd_send &&
        (proto_eff == proto_tcp || proto_eff == proto_udp);
      act_use_dest_mac <= go && cmd_ff == cmd_send_direct_mac;
      if (go && (cmd_ff == cmd_send || cmd_ff == cmd_send_direct_mac)) begin
        act_send_len <= wsize_ff;
      end
      keepalive_packet <= go && cmd_ff == cmd_keepalive;
      act_recv_done <= go && cmd_ff == cmd_recv_done;
      act_ppp <= go && cmd_ff >= cmd_session_start && cmd_ff <= cmd_phase_reject;
      act_ppp_cmd <= go ? cmd_ff : cmd_none;
    end
  end

  // unmatched port: reset reply, status untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_rst_reply <= 1'b0;
    end else begin
      act_rst_reply <= evt_no_port;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_cmd_self_clear: assert property (
    (exec && !(wr && idx == IDX_COMMAND)) |=> cmd_ff == cmd_none)
    else $error("command register not cleared");
  chk_listen_success: assert property ((state_ff == state_listening && evt_syn_ok &&
    !tcp_timeout && !evt_rst_rx) |=> state_ff == state_connected && flags[FLG_CONNECT])
    else $error("listen success not handled");
  chk_connect_start: assert property ((exec && cmd_ff == cmd_connect && in_tcp &&
    state_ff == state_tcp_init) |=> act_syn && state_ff == state_syn_sent)
    else $error("connect did not start");
  chk_connect_fail: assert property ((state_ff == state_syn_sent &&
    (arp_timeout || tcp_timeout) && !evt_synack_rx) |=>
    state_ff == state_closed && flags[FLG_TIMEOUT])
    else $error("connect failure not closed");
  chk_rst_forces: assert property ((tcp_live && evt_rst_rx) |=>
    state_ff == state_closed)
    else $error("peer reset ignored");
  chk_close_cmd: assert property ((exec && cmd_ff == cmd_close) |=>
    state_ff == state_closed && !act_fin)
    else $error("close did not close");
  chk_flag_hold: assert property ((flags[FLG_TIMEOUT] && !flag_clr[FLG_TIMEOUT]) |=>
    flags[FLG_TIMEOUT])
    else $error("timeout flag dropped");
  chk_ka_ignored: assert property ((exec && cmd_ff == cmd_keepalive &&
    ka_timer_ff != '0) |=> !keepalive_packet)
    else $error("keepalive with running timer");
  chk_rst_reply: assert property (evt_no_port |=> act_rst_reply)
    else $error("no reset reply");
  chk_invalid_cmd: assert property ((exec && !dif.cmd_ok && !tcp_live &&
    !(wr && idx == IDX_COMMAND)) |=> state_ff == $past(state_ff) && cmd_ff == cmd_none)
    else $error("invalid command changed status");
  chk_raw_sock0: assert property ((exec && cmd_ff == cmd_open && sock_id_ff != '0 &&
    proto_field == proto_mac_raw) |=> state_ff == $past(state_ff))
    else $error("mac raw opened off socket zero");
  chk_free_credit: assert property ((in_tcp && evt_data_ack && !act_send_pre) |=>
    free_ff == $past(free_ff) + $past(evt_ack_size))
    else $error("free size not credited");

  cov_established: cover property (state_ff == state_syn_sent ##1 state_ff == state_connected);
  cov_send_done: cover property (act_send ##[1:50] flags[send_complete_flag]);
  cov_pppoe_cmd: cover property (act_ppp && act_ppp_cmd == cmd_session_start);
endmodule // sce_engine
`default_nettype wire

// file: rtl/sce_sticky_bit.sv
`timescale 1ns/1ns
`default_nettype none
// one event flag; a set in the clear cycle wins so no event is lost
module sce_sticky_bit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set_in,
  input wire logic clr_in,
  output logic flag_ff
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 1'b0;
    end else if (set_in) begin
      flag_ff <= 1'b1;
    end else if (clr_in) begin
      flag_ff <= 1'b0;
    end
  end
endmodule // sce_sticky_bit
`default_nettype wire

// file: rtl/unused_placeholder_removed.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire
